// ===== src/sifc_codec.sv
// Serial infrared pulse codec with an AXI4-Lite register slave.
// Assumes the system clock doubles as the crystal; all pins are asynchronous.
module sifc_codec (
	input wire logic clock,
	input wire logic rst,
	input wire logic [3:0] axi_awaddr,
	input wire logic axi_awvalid,
	output logic axi_awready,
	input wire logic [31:0] axi_wdata,
	input wire logic [3:0] axi_wstrb,
	input wire logic axi_wvalid,
	output logic axi_wready,
	output logic [1:0] axi_bresp,
	output logic axi_bvalid,
	input wire logic axi_bready,
	input wire logic [3:0] axi_araddr,
	input wire logic axi_arvalid,
	output logic axi_arready,
	output logic [31:0] axi_rdata,
	output logic [1:0] axi_rresp,
	output logic axi_rvalid,
	input wire logic axi_rready,
	input wire logic rate_code_bit2,
	input wire logic rate_code_bit1,
	input wire logic rate_code_bit0,
	input wire logic pulse_width_select,
	input wire logic power_down_in,
	input wire logic uart_transmit_in,
	input wire logic infrared_receive_in_n,
	input wire logic sixteen_times_bit_clock,
	output logic uart_receive_out,
	output logic infrared_transmit_out
);
	typedef enum logic {ENC_IDLE, ENC_BIT} sifc_enc_e;

	sifc_pkg::sifc_pins_s pins;
	sifc_pkg::sifc_ctrl_s ctrl;
	sifc_enc_e enc_state;
	logic [3:0] enc_phase;
	logic [6:0] divisor;
	logic [6:0] div_cnt;
	logic int_tick;
	logic ext_prev;
	logic ext_rise;
	logic tick;
	logic power_down;
	logic mod_pulse;
	logic mod_prev;
	logic [2:0] mono_cnt;
	logic rx_prev_n;
	logic rx_fall;
	logic push;
	logic in_ready;
	logic out_valid;
	logic pop;
	logic [4:0] buf_mem [2];
	logic wr_ptr;
	logic rd_ptr;
	logic [1:0] buf_count;
	logic [4:0] str_cnt;
	logic overrun;
	logic [15:0] tx_count;
	logic [15:0] rx_count;
	logic aw_have;
	logic w_have;
	logic [3:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic do_write;
	logic clear_overrun;
	logic [31:0] status_word;

	sifc_sync #(
		.W(8),
		.INIT(sifc_pkg::PINS_RESET)
	) u_pin_sync (
		.clock(clock),
		.rst(rst),
		.d({rate_code_bit2, rate_code_bit1, rate_code_bit0, pulse_width_select,
			power_down_in, uart_transmit_in, infrared_receive_in_n, sixteen_times_bit_clock}),
		.q(pins)
	);

	assign power_down = pins.power_down | ctrl.sw_power_down;

	// Crystal divisor lookup
	always_comb
	begin
		unique case (pins.rate_code)
			sifc_pkg::RATE_DIV2: divisor = sifc_pkg::DIVIDE_2;
			sifc_pkg::RATE_DIV4: divisor = sifc_pkg::DIVIDE_4;
			sifc_pkg::RATE_DIV12: divisor = sifc_pkg::DIVIDE_12;
			sifc_pkg::RATE_DIV24: divisor = sifc_pkg::DIVIDE_24;
			sifc_pkg::RATE_DIV6: divisor = sifc_pkg::DIVIDE_6;
			sifc_pkg::RATE_DIV48: divisor = sifc_pkg::DIVIDE_48;
			sifc_pkg::RATE_DIV96: divisor = sifc_pkg::DIVIDE_96;
			default: divisor = sifc_pkg::DIVIDE_2;
		endcase
	end

	// A shortened divisor never strands the counter above its wrap point
	assign int_tick = div_cnt >= divisor - 7'h01;
	assign ext_rise = pins.ext_clock & ~ext_prev;
	assign tick = ctrl.clock_source_select ? ext_rise : int_tick;

	always_ff @(posedge clock)
	begin
		if (rst)
			div_cnt <= 7'h00;
		else if (int_tick)
			div_cnt <= 7'h00;
		else
			div_cnt <= div_cnt + 7'h01;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			ext_prev <= 1'b0;
		else
			ext_prev <= pins.ext_clock;
	end

	// Encoder: one 16-tick bit frame per space, restarted while spaces continue
	always_ff @(posedge clock)
	begin
		if (rst || power_down)
		begin
			enc_state <= ENC_IDLE;
			enc_phase <= 4'h0;
		end
		else if (tick)
		begin
			unique case (enc_state)
				ENC_IDLE:
				begin
					if (!pins.uart_tx)
					begin
						enc_state <= ENC_BIT;
						enc_phase <= 4'h0;
					end
				end
				ENC_BIT:
				begin
					if (enc_phase == sifc_pkg::ENC_LAST_PHASE)
					begin
						enc_phase <= 4'h0;
						if (pins.uart_tx)
							enc_state <= ENC_IDLE;
					end
					else
						enc_phase <= enc_phase + 4'h1;
				end
			endcase
		end
	end

	assign mod_pulse = (enc_state == ENC_BIT) && (enc_phase >= sifc_pkg::ENC_WAIT_TICKS)
		&& (enc_phase < sifc_pkg::ENC_WAIT_TICKS + sifc_pkg::ENC_HIGH_TICKS);

	always_ff @(posedge clock)
	begin
		if (rst)
			mod_prev <= 1'b0;
		else
			mod_prev <= mod_pulse;
	end

	// Monoshot retriggers on each modulator rising edge
	always_ff @(posedge clock)
	begin
		if (rst || power_down)
			mono_cnt <= 3'h0;
		else if (mod_pulse && !mod_prev)
			mono_cnt <= sifc_pkg::MONO_CYCLES;
		else if (mono_cnt != 3'h0)
			mono_cnt <= mono_cnt - 3'h1;
	end

	always_ff @(posedge clock)
	begin
		if (rst || power_down)
			infrared_transmit_out <= 1'b0;
		else if (pins.pulse_width_select)
			infrared_transmit_out <= mono_cnt != 3'h0;
		else
			infrared_transmit_out <= mod_pulse;
	end

	// Decoder: receive falling edges queue stretch requests
	always_ff @(posedge clock)
	begin
		if (rst)
			rx_prev_n <= 1'b1;
		else
			rx_prev_n <= pins.ir_rx_n;
	end

	assign rx_fall = rx_prev_n & ~pins.ir_rx_n;
	assign push = rx_fall & ~power_down;
	assign in_ready = buf_count != 2'h2;
	assign out_valid = buf_count != 2'h0;
	// Chaining on the last tick keeps back-to-back spaces seamless
	assign pop = out_valid && ((str_cnt == 5'h00) || (str_cnt == 5'h01 && tick));

	always_ff @(posedge clock)
	begin
		if (rst || power_down)
		begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			buf_count <= 2'h0;
		end
		else
		begin
			if (push && in_ready)
			begin
				buf_mem[wr_ptr] <= sifc_pkg::BIT_TICKS;
				wr_ptr <= ~wr_ptr;
			end
			if (pop)
				rd_ptr <= ~rd_ptr;
			buf_count <= buf_count + {1'b0, push && in_ready} - {1'b0, pop};
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst || power_down)
			str_cnt <= 5'h00;
		else if (pop)
			str_cnt <= buf_mem[rd_ptr];
		else if (tick && str_cnt != 5'h00)
			str_cnt <= str_cnt - 5'h01;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			uart_receive_out <= 1'b1;
		else
			uart_receive_out <= str_cnt == 5'h00;
	end

	// Event counters and sticky overrun, where a new overrun beats a clear
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			tx_count <= 16'h0000;
			rx_count <= 16'h0000;
		end
		else
		begin
			if (mod_pulse && !mod_prev)
				tx_count <= tx_count + 16'h0001;
			if (push && in_ready)
				rx_count <= rx_count + 16'h0001;
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			overrun <= 1'b0;
		else if (push && !in_ready)
			overrun <= 1'b1;
		else if (clear_overrun)
			overrun <= 1'b0;
	end

	// Register slave: write path
	assign do_write = aw_have && w_have && !axi_bvalid;
	assign clear_overrun = do_write && aw_addr_q == sifc_pkg::ADDR_STATUS && w_strb_q[0]
		&& w_data_q[sifc_pkg::STAT_OVERRUN];

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			aw_have <= 1'b0;
			axi_awready <= 1'b0;
			aw_addr_q <= 4'h0;
		end
		else if (axi_awvalid && axi_awready)
		begin
			aw_have <= 1'b1;
			axi_awready <= 1'b0;
			aw_addr_q <= axi_awaddr;
		end
		else if (do_write || !aw_have)
		begin
			aw_have <= 1'b0;
			axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			w_have <= 1'b0;
			axi_wready <= 1'b0;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
		end
		else if (axi_wvalid && axi_wready)
		begin
			w_have <= 1'b1;
			axi_wready <= 1'b0;
			w_data_q <= axi_wdata;
			w_strb_q <= axi_wstrb;
		end
		else if (do_write || !w_have)
		begin
			w_have <= 1'b0;
			axi_wready <= 1'b1;
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			ctrl <= sifc_pkg::CTRL_RESET;
		else if (do_write && aw_addr_q == sifc_pkg::ADDR_CTRL && w_strb_q[0])
			ctrl <= w_data_q[1:0];
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			axi_bvalid <= 1'b0;
			axi_bresp <= sifc_pkg::RESP_OKAY;
		end
		else if (do_write)
		begin
			axi_bvalid <= 1'b1;
			axi_bresp <= aw_addr_q[1:0] != 2'h0 ? sifc_pkg::RESP_SLVERR : sifc_pkg::RESP_OKAY;
		end
		else if (axi_bready)
			axi_bvalid <= 1'b0;
	end

	// Register slave: read path, one cycle from address to data
	always_comb
	begin
		status_word = 32'h00000000;
		status_word[sifc_pkg::STAT_TX_ACTIVE] = enc_state == ENC_BIT;
		status_word[sifc_pkg::STAT_RX_STRETCH] = str_cnt != 5'h00;
		status_word[sifc_pkg::STAT_OVERRUN] = overrun;
		status_word[sifc_pkg::STAT_POWER_DOWN] = power_down;
		status_word[sifc_pkg::STAT_EXT_CLOCK] = ctrl.clock_source_select;
		status_word[sifc_pkg::STAT_RATE_LSB +: 3] = pins.rate_code;
		status_word[sifc_pkg::STAT_WIDTH_SEL] = pins.pulse_width_select;
		status_word[sifc_pkg::STAT_BUF_LSB +: 2] = buf_count;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			axi_arready <= 1'b0;
			axi_rvalid <= 1'b0;
			axi_rdata <= 32'h00000000;
			axi_rresp <= sifc_pkg::RESP_OKAY;
		end
		else if (axi_arvalid && axi_arready)
		begin
			axi_arready <= 1'b0;
			axi_rvalid <= 1'b1;
			axi_rresp <= axi_araddr[1:0] != 2'h0 ? sifc_pkg::RESP_SLVERR : sifc_pkg::RESP_OKAY;
			unique case (axi_araddr[3:2])
				2'h0: axi_rdata <= {30'h0, ctrl};
				2'h1: axi_rdata <= status_word;
				2'h2: axi_rdata <= {16'h0000, tx_count};
				2'h3: axi_rdata <= {16'h0000, rx_count};
			endcase
		end
		else if (axi_rvalid && axi_rready)
		begin
			axi_rvalid <= 1'b0;
			axi_arready <= 1'b1;
		end
		else if (!axi_rvalid)
			axi_arready <= 1'b1;
	end

	default clocking @(posedge clock);
	endclocking
	default disable iff (rst);

	chk_divider_wrap: assert property (!ctrl.clock_source_select && tick |=> div_cnt == 7'h00)
		else $error("divider did not wrap on tick");
	chk_rate_fallback: assert property (pins.rate_code == 3'h7 |-> divisor == 7'h02)
		else $error("undefined rate code not treated as divide by two");
	chk_space_starts: assert property (enc_state == ENC_IDLE && tick && !pins.uart_tx
		&& !power_down |=> enc_state == ENC_BIT && enc_phase == 4'h0)
		else $error("space bit did not start a frame");
	chk_pulse_phase: assert property ($rose(mod_pulse) |-> $past(enc_phase) == 4'h6
		&& enc_phase == 4'h7)
		else $error("pulse did not start after seven ticks");
	chk_pulse_end: assert property ($fell(mod_pulse) && !power_down
		|-> enc_phase == 4'hA)
		else $error("pulse was not three ticks long");
	chk_space_repeat: assert property (enc_state == ENC_BIT && enc_phase == 4'hF && tick
		&& !pins.uart_tx && !power_down |=> enc_state == ENC_BIT && enc_phase == 4'h0)
		else $error("consecutive space not sixteen ticks apart");
	chk_mark_quiet: assert property (enc_state == ENC_IDLE && !pins.pulse_width_select
		|=> !infrared_transmit_out)
		else $error("emitter lit during mark");
	chk_rx_edge_queued: assert property (rx_fall && !power_down && in_ready
		|=> buf_count != 2'h0 || str_cnt != 5'h00)
		else $error("receive edge lost");
	chk_rx_stretch: assert property (pop && !power_down |=> str_cnt == 5'h10 ##1 !uart_receive_out)
		else $error("receive space not started for sixteen ticks");
	chk_monoshot_width: assert property (mod_pulse && !mod_prev && !power_down
		|=> (mono_cnt != 3'h0) [*6] ##1 mono_cnt == 3'h0 || mod_pulse)
		else $error("monoshot width not six cycles");
	chk_power_quiet: assert property (power_down |=> !infrared_transmit_out
		&& enc_state == ENC_IDLE && str_cnt == 5'h00)
		else $error("activity while powered down");
	// Without a rising edge on the external pin the encoder must not advance
	chk_clock_select: assert property (ctrl.clock_source_select && !(pins.ext_clock && !ext_prev)
		&& !power_down |=> $stable(enc_phase))
		else $error("external clock not selected");
endmodule

// ===== src/sifc_pkg.sv
// Shared constants and types for the serial infrared pulse codec.
// Assumes a 50 MHz system clock that also serves as the crystal clock.
package sifc_pkg;
	localparam int unsigned CLK_HZ = 50_000_000;

	// 16x clock division per rate code
	localparam logic [2:0] RATE_DIV2 = 3'h0;
	localparam logic [2:0] RATE_DIV4 = 3'h1;
	localparam logic [2:0] RATE_DIV12 = 3'h2;
	localparam logic [2:0] RATE_DIV24 = 3'h3;
	localparam logic [2:0] RATE_DIV6 = 3'h4;
	localparam logic [2:0] RATE_DIV48 = 3'h5;
	localparam logic [2:0] RATE_DIV96 = 3'h6;
	localparam logic [6:0] DIVIDE_2 = 7'h02;
	localparam logic [6:0] DIVIDE_4 = 7'h04;
	localparam logic [6:0] DIVIDE_12 = 7'h0C;
	localparam logic [6:0] DIVIDE_24 = 7'h18;
	localparam logic [6:0] DIVIDE_6 = 7'h06;
	localparam logic [6:0] DIVIDE_48 = 7'h30;
	localparam logic [6:0] DIVIDE_96 = 7'h60;

	// Encoder and decoder timing in 16x clock ticks, monoshot in crystal cycles
	localparam logic [3:0] ENC_WAIT_TICKS = 4'h7;
	localparam logic [3:0] ENC_HIGH_TICKS = 4'h3;
	localparam logic [3:0] ENC_LAST_PHASE = 4'hF;
	localparam logic [4:0] BIT_TICKS = 5'h10;
	localparam logic [2:0] MONO_CYCLES = 3'h6;

	// Register byte addresses
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_TX_COUNT = 4'h8;
	localparam logic [3:0] ADDR_RX_COUNT = 4'hC;

	// Status field positions
	localparam int STAT_TX_ACTIVE = 0;
	localparam int STAT_RX_STRETCH = 1;
	localparam int STAT_OVERRUN = 2;
	localparam int STAT_POWER_DOWN = 3;
	localparam int STAT_EXT_CLOCK = 4;
	localparam int STAT_RATE_LSB = 5;
	localparam int STAT_WIDTH_SEL = 8;
	localparam int STAT_BUF_LSB = 9;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic clock_source_select;
		logic sw_power_down;
	} sifc_ctrl_s;

	localparam sifc_ctrl_s CTRL_RESET = '{clock_source_select: 1'b0, sw_power_down: 1'b0};

	// Pin inputs after synchronisation
	typedef struct packed {
		logic [2:0] rate_code;
		logic pulse_width_select;
		logic power_down;
		logic uart_tx;
		logic ir_rx_n;
		logic ext_clock;
	} sifc_pins_s;

	// Idle levels: UART line and infrared receive line rest high
	localparam sifc_pins_s PINS_RESET = 8'h06;
endpackage

// ===== src/sifc_sync.sv
// Two-stage synchroniser for a vector of asynchronous inputs.
// Assumes each bit is independent; no multi-bit coherence is implied.
module sifc_sync #(
	parameter int W = 8,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			meta <= INIT;
			q <= INIT;
		end
		else
		begin
			meta <= d;
			q <= meta;
		end
	end
endmodule

// ===== testbench/sifc_ir_far_end.sv
// Far-end transceiver model: measures emitted pulses, sends received pulses.
// Assumes the emitter output is high while lit; receive line rests high.
module sifc_ir_far_end (
	input wire logic clock,
	input wire logic ir_on,
	output logic ir_rx_n
);
	timeunit 1ns;
	timeprecision 1ns;
	int cyc = 0;
	int w = 0;
	int rises[$];
	int widths[$];
	initial ir_rx_n = 1'h1;
	always @(posedge clock)
	begin
		cyc++;
		if (ir_on && w == 0)
			rises.push_back(cyc);
		if (ir_on)
			w++;
		else if (w > 0)
		begin
			widths.push_back(w);
			w = 0;
		end
	end
	// Active-low pulse, one falling edge per received bit
	task fire();
		@(posedge clock);
		ir_rx_n <= 1'h0;
		repeat (8) @(posedge clock);
		ir_rx_n <= 1'h1;
	endtask
endmodule

// ===== testbench/tb_top.sv
// Bench for the infrared codec: AXI register access, pin stimulus, queue model.
// Assumes sifc_pkg, sifc_codec and the far-end model are compiled first.
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 1'h0;
	logic rst = 1'h1;
	logic [3:0] axi_awaddr = 4'h0, axi_wstrb = 4'hF, axi_araddr = 4'h0;
	logic axi_awvalid = 1'h0, axi_wvalid = 1'h0, axi_bready = 1'h0;
	logic axi_arvalid = 1'h0, axi_rready = 1'h0;
	logic [31:0] axi_wdata = 32'h0, axi_rdata;
	logic axi_awready, axi_wready, axi_bvalid, axi_arready, axi_rvalid;
	logic [1:0] axi_bresp, axi_rresp;
	logic [2:0] rc = 3'h0;
	logic pulse_width_select = 1'h0, power_down_in = 1'h0, uart_transmit_in = 1'h1;
	logic sixteen_times_bit_clock = 1'h0, ext_on = 1'h0;
	logic infrared_receive_in_n, uart_receive_out, infrared_transmit_out;
	int miscompares = 0, samples_checked = 0, cycles = 0, div = 2;
	int rx_edges = 0, rx_len = 0, lowc = 0, tx_total = 0, rx_total = 0, e1 = 0;
	int divs[8] = '{2, 4, 12, 24, 6, 48, 96, 2};
	int exp_q[$];
	sifc_codec i_sifc_codec (.clock, .rst, .axi_awaddr, .axi_awvalid, .axi_awready,
		.axi_wdata, .axi_wstrb, .axi_wvalid, .axi_wready, .axi_bresp, .axi_bvalid,
		.axi_bready, .axi_araddr, .axi_arvalid, .axi_arready, .axi_rdata, .axi_rresp,
		.axi_rvalid, .axi_rready, .rate_code_bit2(rc[2]), .rate_code_bit1(rc[1]),
		.rate_code_bit0(rc[0]), .pulse_width_select, .power_down_in, .uart_transmit_in,
		.infrared_receive_in_n, .sixteen_times_bit_clock, .uart_receive_out,
		.infrared_transmit_out);
	sifc_ir_far_end far (.clock, .ir_on(infrared_transmit_out), .ir_rx_n(infrared_receive_in_n));
	initial forever #10 clock = ~clock;
	always @(posedge clock)
	begin
		cycles++;
		if (ext_on && cycles % 4 == 0)
			sixteen_times_bit_clock <= ~sixteen_times_bit_clock;
		if (!uart_receive_out)
			lowc++;
		else if (lowc > 0)
		begin
			rx_len = lowc;
			lowc = 0;
			rx_edges++;
		end
		if (cycles == 90000)
		begin
			miscompares++;
			conclude();
		end
	end
	task conclude();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		samples_checked++;
		if (s !== e)
		begin
			$display("wrong value %s expected %0h seen %0h", n, e, s);
			miscompares++;
		end
	endtask
	task aw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge clock);
		axi_awaddr <= a;
		axi_wdata <= d;
		axi_awvalid <= 1'h1;
		axi_wvalid <= 1'h1;
		axi_bready <= 1'h1;
		do
		begin
			@(posedge clock);
			if (axi_awready)
				axi_awvalid <= 1'h0;
			if (axi_wready)
				axi_wvalid <= 1'h0;
		end while ((axi_awvalid & ~axi_awready) | (axi_wvalid & ~axi_wready));
		while (!axi_bvalid) @(posedge clock);
		axi_bready <= 1'h0;
		chk("bresp", er, axi_bresp);
	endtask
	task ar(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge clock);
		axi_araddr <= a;
		axi_arvalid <= 1'h1;
		axi_rready <= 1'h1;
		do @(posedge clock); while (!axi_arready);
		axi_arvalid <= 1'h0;
		do @(posedge clock); while (!axi_rvalid);
		axi_rready <= 1'h0;
		chk("rresp", er, axi_rresp);
		if (er == 2'h0)
			chk("rdata", ed, axi_rdata);
	endtask
	// Start bit, eight data bits from the lsb, stop bit; line held high after
	task frame(input logic [7:0] d);
		logic [9:0] b;
		int t0;
		int pw;
		b = {1'h1, d, 1'h0};
		pw = pulse_width_select ? 6 : 3 * div;
		far.rises.delete();
		far.widths.delete();
		exp_q.delete();
		for (int i = 0; i < 10; i++)
		begin
			if (!b[i] && !power_down_in)
				exp_q.push_back(i);
			@(posedge clock);
			uart_transmit_in <= b[i];
			if (i == 0)
				t0 = far.cyc + 1;
			repeat (16 * div - 1) @(posedge clock);
		end
		repeat (20 * div) @(posedge clock);
		tx_total += exp_q.size();
		chk("pulses", exp_q.size(), far.widths.size());
		if (exp_q.size() == far.widths.size() && exp_q.size() > 0)
		begin
			chk("delay", 1, far.rises[0] - t0 >= 7 * div && far.rises[0] - t0 <= 8 * div + 6);
			foreach (far.widths[k])
			begin
				chk("width", pw, far.widths[k]);
				chk("space", (exp_q[k] - exp_q[0]) * 16 * div, far.rises[k] - far.rises[0]);
			end
		end
	endtask
	task rxp(input int n);
		int e0;
		e0 = rx_edges;
		repeat (n)
		begin
			far.fire();
			repeat (20 * div) @(posedge clock);
		end
		if (!power_down_in)
			rx_total += n;
		chk("rx spaces", power_down_in ? 0 : n, rx_edges - e0);
		if (!power_down_in)
			chk("rx length", 1, rx_len >= 15 * div && rx_len <= 16 * div + 2);
	endtask
	initial
	begin
		void'($urandom(76));
		repeat (2) @(posedge clock);
		rst <= 1'h0;
		repeat (3) @(posedge clock);
		ar(4'h0, 32'h0, 2'h0);
		ar(4'h4, 32'h0, 2'h0);
		aw(4'h0, 32'h1, 2'h0);
		ar(4'h4, 32'h8, 2'h0);
		aw(4'h0, 32'h0, 2'h0);
		ar(4'h2, 32'h0, 2'h2);
		aw(4'h2, 32'h1, 2'h2);
		ar(4'h0, 32'h0, 2'h0);
		$display("test registers done");
		for (int c = 0; c < 8; c++)
		begin
			rc <= 3'(c);
			div = divs[c];
			repeat (8) @(posedge clock);
			frame(8'($urandom()));
		end
		$display("test rate codes done");
		pulse_width_select <= 1'h1;
		rc <= 3'h3;
		div = 24;
		repeat (8) @(posedge clock);
		frame(8'h55);
		pulse_width_select <= 1'h0;
		$display("test monoshot done");
		rc <= 3'h1;
		div = 4;
		repeat (8) @(posedge clock);
		rxp(3);
		$display("test receive done");
		// Four edges inside one stretch: two queue, the fourth overruns
		e1 = rx_edges;
		repeat (4) far.fire();
		ar(4'h4, 32'h426, 2'h0);
		aw(4'h4, 32'h4, 2'h0);
		repeat (80 * div) @(posedge clock);
		ar(4'h4, 32'h20, 2'h0);
		chk("rx chained", 1, rx_edges - e1);
		chk("rx chained length", 1, rx_len >= 47 * div && rx_len <= 48 * div + 2);
		rx_total += 3;
		$display("test overrun done");
		power_down_in <= 1'h1;
		repeat (8) @(posedge clock);
		frame(8'h00);
		rxp(2);
		power_down_in <= 1'h0;
		$display("test power down done");
		aw(4'h0, 32'h2, 2'h0);
		ext_on <= 1'h1;
		div = 8;
		repeat (40) @(posedge clock);
		frame(8'($urandom()));
		rxp(2);
		$display("test external clock done");
		ar(4'h8, 32'(tx_total), 2'h0);
		ar(4'hC, 32'(rx_total), 2'h0);
		$display("test counters done");
		conclude();
	end
endmodule
